// File: irq_prio_regs.svh
// register offsets, reset values and field positions of the interrupt prioritizer
`ifndef IRQ_PRIO_REGS_SVH
`define IRQ_PRIO_REGS_SVH
`define OFS_REQUEST_GROUP0 12'h0fc0
`define OFS_ENABLE_HI_GROUP0 12'h0fc1
`define OFS_ENABLE_LO_GROUP0 12'h0fc2
`define OFS_REQUEST_GROUP1 12'h0fc3
`define OFS_ENABLE_HI_GROUP1 12'h0fc4
`define OFS_ENABLE_LO_GROUP1 12'h0fc5
`define OFS_REQUEST_GROUP2 12'h0fc6
`define OFS_ENABLE_HI_GROUP2 12'h0fc7
`define OFS_ENABLE_LO_GROUP2 12'h0fc8
`define OFS_EDGE_POLARITY_SELECT 12'h0fcd
`define OFS_SHARED_SOURCE_SELECT 12'h0fce
`define OFS_IRQ_STATUS 12'h0fd0
`define OFS_IRQ_MASK 12'h0fd1
`define OFS_ACTIVE_VECTOR 12'h0fd2
`define RST_REG8 8'h00
`define SHARED_SEL_BIT 3'd6
`define STATUS_BIT_TAKE 0
`define STATUS_BIT_LOST 1
`endif

// File: irq_prio_pkg.sv
// types shared by the interrupt prioritizer files
package irq_prio_pkg;
    typedef logic [1:0] prio_t;
    typedef enum logic [1:0] {
        PRIO_OFF = 2'b00,
        PRIO_LOW = 2'b01,
        PRIO_MID = 2'b10,
        PRIO_HIGH = 2'b11
    } prio_level_e;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_REQ = 2'b01,
        ST_ACK = 2'b10
    } vec_state_e;
endpackage

// File: irq_edge_detect.sv
// per-pin edge detection for the port interrupt inputs
module irq_edge_detect
    import irq_prio_pkg::*;
#(
    parameter int WIDTH = 12,
    parameter int SEL_WIDTH = 8
) (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic [WIDTH-1:0] pin_in,
    input wire logic [SEL_WIDTH-1:0] falling_sel_in,
    output logic [WIDTH-1:0] edge_out
);
    logic [WIDTH-1:0] last_pin;
    logic [WIDTH-1:0] next_edge;

    initial begin
        if (SEL_WIDTH > WIDTH) begin
            $error("more selectable inputs than inputs");
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            last_pin <= '0;
        end else begin
            last_pin <= pin_in;
        end
    end

    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            if (i < SEL_WIDTH) begin
                // single edge, polarity chosen per pin
                next_edge[i] = falling_sel_in[i] ? (last_pin[i] & ~pin_in[i])
                                                 : (~last_pin[i] & pin_in[i]);
            end else begin
                next_edge[i] = last_pin[i] ^ pin_in[i];
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            edge_out <= '0;
        end else begin
            edge_out <= next_edge;
        end
    end
endmodule

// File: irq_prioritizer.sv
// vectored interrupt prioritizer: requests, enables, arbitration, vector hand-off
//
// The plain strobed port was decided locally.
`include "irq_prio_regs.svh"

// Behaviour
// - arbitrate pending peripheral and port requests; forward only the winner
// - seventeen sources fold onto sixteen vectors
// - twelve port pin sources, five peripheral sources
// - comparator and port_a_pin_six share one vector
// - eight port inputs trigger on a chosen rising or falling edge
// - four port inputs trigger on both edges
// - each source has software priority of three levels, used in arbitration
// - watchdog is an accepted request source
// - in polled mode vectoring has no effect; arbitration still feeds the active vector readback
// - absent adc or unbonded pins remove those sources
module irq_prioritizer
    import irq_prio_pkg::*;
#(
    parameter int NUM_VEC = 16,
    parameter int NUM_PORT = 12,
    parameter int NUM_SEL_EDGE = 8,
    parameter logic HAS_ADC = 1'b1,
    parameter logic [11:0] PORT_BONDED = 12'h0fff
) (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic [11:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    input wire logic [11:0] port_pin_in,
    input wire logic watchdog_irq_in,
    input wire logic timer_irq_in,
    input wire logic adc_irq_in,
    input wire logic comparator_irq_in,
    input wire logic uart_irq_in,
    input wire logic vectored_mode_in,
    input wire logic core_ack_in,
    output logic core_irq_out,
    output logic [3:0] core_vector_out,
    output logic irq_out
);
    logic [7:0] request_group0;
    logic [7:0] request_group1;
    logic [7:0] request_group2;
    logic [7:0] enable_hi_group0;
    logic [7:0] enable_lo_group0;
    logic [7:0] enable_hi_group1;
    logic [7:0] enable_lo_group1;
    logic [7:0] enable_hi_group2;
    logic [7:0] enable_lo_group2;
    logic [7:0] edge_polarity_select;
    logic [7:0] shared_source_select;
    logic [7:0] irq_status;
    logic [7:0] irq_mask;
    logic [11:0] port_edge;
    logic [NUM_VEC-1:0] src_event;
    logic [NUM_VEC-1:0] pending;
    logic [NUM_VEC-1:0] enable_hi;
    logic [NUM_VEC-1:0] enable_lo;
    logic [NUM_VEC-1:0] ack_clear;
    logic win_valid;
    logic [3:0] win_vec;
    logic [1:0] win_prio;
    vec_state_e state;
    vec_state_e next_state;
    logic ev_take;
    logic ev_lost;
    logic [7:0] next_rdata;
    prio_t src_prio [NUM_VEC];
    prio_t top_prio;
    logic wr_req0;
    logic wr_req1;
    logic wr_req2;
    logic rd_status;

    initial begin
        if (NUM_VEC != 16 || NUM_PORT != 12 || NUM_SEL_EDGE != 8) begin
            $error("vector map is fixed at 16 vectors, 12 port sources, 8 selectable");
        end
    end

    function automatic prio_t level_of(input logic hi, input logic lo);
        return {hi, lo};
    endfunction

    function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
        return a == ofs;
    endfunction

    irq_edge_detect #(
        .WIDTH(NUM_PORT),
        .SEL_WIDTH(NUM_SEL_EDGE)
    ) u_edge (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .pin_in(port_pin_in),
        .falling_sel_in(edge_polarity_select),
        .edge_out(port_edge)
    );

    // vector order: 0 watchdog, 1 timer, 2 adc, 3 uart, 4..15 port pins 0..11
    always_comb begin
        src_event = '0;
        src_event[0] = watchdog_irq_in;
        src_event[1] = timer_irq_in;
        src_event[2] = adc_irq_in & HAS_ADC;
        src_event[3] = uart_irq_in;
        src_event[15:4] = port_edge & PORT_BONDED;
        // port_a_pin_six line carries comparator when shared select is set
        if (shared_source_select[`SHARED_SEL_BIT]) begin
            src_event[4 + 6] = comparator_irq_in;
        end
    end

    assign pending = {request_group1, request_group0};
    assign enable_hi = {enable_hi_group1, enable_hi_group0};
    assign enable_lo = {enable_lo_group1, enable_lo_group0};

    // per-source level from the two enable bits
    always_comb begin
        for (int i = 0; i < NUM_VEC; i++) begin
            src_prio[i] = level_of(enable_hi[i], enable_lo[i]);
        end
    end

    // first pass: highest level among pending sources
    always_comb begin
        top_prio = PRIO_OFF;
        for (int i = 0; i < NUM_VEC; i++) begin
            if (pending[i] && src_prio[i] > top_prio) begin
                top_prio = src_prio[i];
            end
        end
    end

    // second pass: lowest vector at that level wins the tie
    always_comb begin
        win_valid = 1'b0;
        win_vec = 4'h0;
        win_prio = top_prio;
        for (int i = NUM_VEC - 1; i >= 0; i--) begin
            if (pending[i] && top_prio != PRIO_OFF && src_prio[i] == top_prio) begin
                win_valid = 1'b1;
                win_vec = 4'(i);
            end
        end
    end

    // core hand-off; the core fetches the 2-byte vector itself
    always_comb begin
        next_state = state;
        ev_take = 1'b0;
        case (state)
            ST_IDLE: begin
                if (win_valid && vectored_mode_in) begin
                    next_state = ST_REQ;
                end
            end
            ST_REQ: begin
                if (!vectored_mode_in) begin
                    next_state = ST_IDLE;
                end else if (core_ack_in) begin
                    next_state = ST_ACK;
                    ev_take = 1'b1;
                end
            end
            ST_ACK: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            core_irq_out <= 1'b0;
            core_vector_out <= 4'h0;
        end else begin
            core_irq_out <= (next_state == ST_REQ);
            if (state == ST_IDLE && win_valid) begin
                core_vector_out <= win_vec;
            end
        end
    end

    always_comb begin
        ack_clear = '0;
        if (ev_take) begin
            ack_clear[core_vector_out] = 1'b1;
        end
    end

    assign ev_lost = |(src_event & pending);

    assign wr_req0 = wr_in && hit(addr_in, `OFS_REQUEST_GROUP0);
    assign wr_req1 = wr_in && hit(addr_in, `OFS_REQUEST_GROUP1);
    assign wr_req2 = wr_in && hit(addr_in, `OFS_REQUEST_GROUP2);
    assign rd_status = rd_in && hit(addr_in, `OFS_IRQ_STATUS);

    // request bits: hardware set beats software or acknowledge clear
    // group2 has no sources wired; kept as plain storage
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            request_group0 <= `RST_REG8;
            request_group1 <= `RST_REG8;
            request_group2 <= `RST_REG8;
        end else begin
            if (wr_req0) begin
                request_group0 <= wdata_in | src_event[7:0];
            end else begin
                request_group0 <= (request_group0 & ~ack_clear[7:0]) | src_event[7:0];
            end
            if (wr_req1) begin
                request_group1 <= wdata_in | src_event[15:8];
            end else begin
                request_group1 <= (request_group1 & ~ack_clear[15:8]) | src_event[15:8];
            end
            if (wr_req2) begin
                request_group2 <= wdata_in;
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            enable_hi_group0 <= `RST_REG8;
            enable_lo_group0 <= `RST_REG8;
            enable_hi_group1 <= `RST_REG8;
            enable_lo_group1 <= `RST_REG8;
            enable_hi_group2 <= `RST_REG8;
            enable_lo_group2 <= `RST_REG8;
        end else if (wr_in) begin
            case (addr_in)
                `OFS_ENABLE_HI_GROUP0: enable_hi_group0 <= wdata_in;
                `OFS_ENABLE_LO_GROUP0: enable_lo_group0 <= wdata_in;
                `OFS_ENABLE_HI_GROUP1: enable_hi_group1 <= wdata_in;
                `OFS_ENABLE_LO_GROUP1: enable_lo_group1 <= wdata_in;
                `OFS_ENABLE_HI_GROUP2: enable_hi_group2 <= wdata_in;
                `OFS_ENABLE_LO_GROUP2: enable_lo_group2 <= wdata_in;
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            edge_polarity_select <= `RST_REG8;
        end else if (wr_in && hit(addr_in, `OFS_EDGE_POLARITY_SELECT)) begin
            edge_polarity_select <= wdata_in;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            shared_source_select <= `RST_REG8;
        end else if (wr_in && hit(addr_in, `OFS_SHARED_SOURCE_SELECT)) begin
            shared_source_select <= wdata_in;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            irq_mask <= `RST_REG8;
        end else if (wr_in && hit(addr_in, `OFS_IRQ_MASK)) begin
            irq_mask <= wdata_in;
        end
    end

    // sticky status, cleared by its read; a new event wins over the clear
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            irq_status <= `RST_REG8;
        end else begin
            if (rd_status) begin
                irq_status <= '0;
            end
            if (ev_take) begin
                irq_status[`STATUS_BIT_TAKE] <= 1'b1;
            end
            if (ev_lost) begin
                irq_status[`STATUS_BIT_LOST] <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(irq_status & irq_mask);
        end
    end

    always_comb begin
        case (addr_in)
            `OFS_REQUEST_GROUP0: next_rdata = request_group0;
            `OFS_ENABLE_HI_GROUP0: next_rdata = enable_hi_group0;
            `OFS_ENABLE_LO_GROUP0: next_rdata = enable_lo_group0;
            `OFS_REQUEST_GROUP1: next_rdata = request_group1;
            `OFS_ENABLE_HI_GROUP1: next_rdata = enable_hi_group1;
            `OFS_ENABLE_LO_GROUP1: next_rdata = enable_lo_group1;
            `OFS_REQUEST_GROUP2: next_rdata = request_group2;
            `OFS_ENABLE_HI_GROUP2: next_rdata = enable_hi_group2;
            `OFS_ENABLE_LO_GROUP2: next_rdata = enable_lo_group2;
            `OFS_EDGE_POLARITY_SELECT: next_rdata = edge_polarity_select;
            `OFS_SHARED_SOURCE_SELECT: next_rdata = shared_source_select;
            `OFS_IRQ_STATUS: next_rdata = irq_status;
            `OFS_IRQ_MASK: next_rdata = irq_mask;
            `OFS_ACTIVE_VECTOR: next_rdata = {win_valid, 1'b0, win_prio, win_vec};
            default: next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            rdata_out <= 8'h00;
        end else if (rd_in) begin
            rdata_out <= next_rdata;
        end else begin
            rdata_out <= 8'h00;
        end
    end
endmodule

// File: irq_prioritizer_checker.sv
// port assertions for the interrupt prioritizer
`include "irq_prio_regs.svh"
module irq_prioritizer_checker (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic [11:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [7:0] rdata_out,
    input wire logic vectored_mode_in,
    input wire logic core_ack_in,
    input wire logic core_irq_out,
    input wire logic [3:0] core_vector_out,
    input wire logic irq_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    logic [15:0] en_hi, en_lo, en_hi_d, en_lo_d;
    logic [7:0] mask;
    // shadow of the group0 and group1 enable registers and the mask register
    always_ff @(posedge clk_sys_in) begin
        en_hi_d <= en_hi;
        en_lo_d <= en_lo;
        if (!rst_n_in) begin
            en_hi <= '0;
            en_lo <= '0;
            mask <= '0;
        end else if (wr_in) begin
            case (addr_in)
                `OFS_ENABLE_HI_GROUP0: en_hi[7:0] <= wdata_in;
                `OFS_ENABLE_LO_GROUP0: en_lo[7:0] <= wdata_in;
                `OFS_ENABLE_HI_GROUP1: en_hi[15:8] <= wdata_in;
                `OFS_ENABLE_LO_GROUP1: en_lo[15:8] <= wdata_in;
                `OFS_IRQ_MASK: mask <= wdata_in;
                default: mask <= mask;
            endcase
        end
    end
    sequence s_taken;
        core_irq_out && core_ack_in;
    endsequence
    AST_ACK_DROP: assert property (s_taken |=> !core_irq_out)
        else $error("request stayed up after acknowledge");
    AST_ACK_STATUS: assert property (s_taken ##0 mask[0] |-> ##2 irq_out)
        else $error("taken interrupt did not raise irq_out");
    AST_HOLD: assert property (core_irq_out && !core_ack_in && vectored_mode_in |=> core_irq_out)
        else $error("request dropped without acknowledge");
    AST_POLLED: assert property (!vectored_mode_in [*2] |-> !core_irq_out)
        else $error("request to core in polled mode");
    AST_GATE: assert property ($rose(core_irq_out) |-> en_hi_d[core_vector_out] || en_lo_d[core_vector_out])
        else $error("request for a source at priority zero");
    AST_IDLE_RD: assert property (!rd_in |=> rdata_out == 8'h00)
        else $error("read data outside the read answer cycle");
    AST_READBACK: assert property (rd_in && addr_in == `OFS_ENABLE_HI_GROUP0 |=> rdata_out == $past(en_hi[7:0]))
        else $error("enable read back mismatch");
    AST_NOMASK: assert property (mask == 8'h00 [*2] |=> !irq_out)
        else $error("irq_out high with mask clear");
endmodule
bind irq_prioritizer irq_prioritizer_checker i_irq_prioritizer_checker (.clk_sys_in, .rst_n_in,
    .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .vectored_mode_in, .core_ack_in,
    .core_irq_out, .core_vector_out, .irq_out);

// File: vector_fetch_core.sv
// processor stand-in: acknowledges requests and fetches the handler address
module vector_fetch_core (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic irq_in,
    input wire logic [3:0] vector_in,
    input wire logic [3:0] delay_in,
    output logic ack_out,
    output logic [3:0] vec_out,
    output logic [15:0] handler_out,
    output int taken_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] prog_mem [32];
    logic [3:0] wait_cnt;
    initial begin
        for (int i = 0; i < 32; i++) begin
            prog_mem[i] = 8'(i * 19 + 5);
        end
    end
    always @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            ack_out <= 1'b0;
            wait_cnt <= 4'h0;
            taken_out <= 0;
        end else if (irq_in && !ack_out && wait_cnt >= delay_in) begin
            ack_out <= 1'b1;
            wait_cnt <= 4'h0;
            vec_out <= vector_in;
            handler_out <= {prog_mem[{vector_in, 1'b0}], prog_mem[{vector_in, 1'b1}]};
            taken_out <= taken_out + 1;
        end else begin
            ack_out <= 1'b0;
            wait_cnt <= irq_in ? wait_cnt + 4'h1 : 4'h0;
        end
    end
endmodule

// File: tb_top.sv
// self-checking bench for the interrupt prioritizer
`include "irq_prio_regs.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fail_count++; \
    $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys_in = 0, rst_n_in = 0, wr_in = 0, rd_in = 0, vectored_mode_in = 0;
    logic [11:0] addr_in = 0, port_pin_in = 0;
    logic [7:0] wdata_in = 0, rdata_out;
    logic [4:0] ev = 0;
    logic core_ack_in, core_irq_out, irq_out;
    logic [3:0] core_vector_out, taken_vec, dly = 0;
    logic [15:0] handler, ehi, elo;
    logic [31:0] seed = 32'h0000_1404;
    int taken, fail_count = 0, n_tests = 0, cyc = 0;
    logic [11:0] ofs [11] = '{`OFS_REQUEST_GROUP0, `OFS_ENABLE_HI_GROUP0, `OFS_ENABLE_LO_GROUP0,
        `OFS_REQUEST_GROUP1, `OFS_ENABLE_HI_GROUP1, `OFS_ENABLE_LO_GROUP1, `OFS_REQUEST_GROUP2,
        `OFS_ENABLE_HI_GROUP2, `OFS_ENABLE_LO_GROUP2, `OFS_EDGE_POLARITY_SELECT,
        `OFS_SHARED_SOURCE_SELECT};
    always #50 clk_sys_in = ~clk_sys_in;
    irq_prioritizer i_irq_prioritizer (.clk_sys_in, .rst_n_in, .addr_in, .wdata_in, .wr_in,
        .rd_in, .rdata_out, .port_pin_in, .watchdog_irq_in(ev[0]), .timer_irq_in(ev[1]),
        .adc_irq_in(ev[2]), .uart_irq_in(ev[3]), .comparator_irq_in(ev[4]), .vectored_mode_in,
        .core_ack_in, .core_irq_out, .core_vector_out, .irq_out);
    vector_fetch_core i_vector_fetch_core (.clk_sys_in, .rst_n_in, .irq_in(core_irq_out),
        .vector_in(core_vector_out), .delay_in(dly), .ack_out(core_ack_in), .vec_out(taken_vec),
        .handler_out(handler), .taken_out(taken));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // highest priority wins, lower vector on a tie
    function automatic int win(input logic [15:0] p);
        int best = -1;
        int bp = 0;
        for (int i = 0; i < 16; i++) begin
            if (p[i] && int'({ehi[i], elo[i]}) > bp) begin
                best = i;
                bp = int'({ehi[i], elo[i]});
            end
        end
        return best;
    endfunction
    function automatic logic [15:0] hexp(input int v);
        return {8'(2 * v * 19 + 5), 8'((2 * v + 1) * 19 + 5)};
    endfunction
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_sys_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_sys_in);
        wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, output logic [7:0] d);
        @(posedge clk_sys_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_sys_in);
        rd_in <= 1'b0;
        @(negedge clk_sys_in);
        d = rdata_out;
    endtask
    task automatic rq(output logic [15:0] p);
        logic [7:0] h, l;
        rd(`OFS_REQUEST_GROUP1, h);
        rd(`OFS_REQUEST_GROUP0, l);
        p = {h, l};
    endtask
    task automatic clr();
        wr(`OFS_REQUEST_GROUP0, 8'h00);
        wr(`OFS_REQUEST_GROUP1, 8'h00);
    endtask
    task automatic en(input logic [15:0] h, input logic [15:0] l);
        ehi = h;
        elo = l;
        wr(`OFS_ENABLE_HI_GROUP0, h[7:0]);
        wr(`OFS_ENABLE_LO_GROUP0, l[7:0]);
        wr(`OFS_ENABLE_HI_GROUP1, h[15:8]);
        wr(`OFS_ENABLE_LO_GROUP1, l[15:8]);
    endtask
    task automatic pulse(input int k);
        @(posedge clk_sys_in);
        ev[k] <= 1'b1;
        @(posedge clk_sys_in);
        ev[k] <= 1'b0;
        repeat (3) @(posedge clk_sys_in);
    endtask
    task automatic pin(input int k, input logic v);
        @(posedge clk_sys_in);
        port_pin_in[k] <= v;
        repeat (4) @(posedge clk_sys_in);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    always @(posedge clk_sys_in) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            results();
        end
    end
    initial begin
        logic [7:0] d, s8;
        logic [15:0] p, q;
        int w, n, exp_n;
        repeat (5) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        for (int i = 0; i < 11; i++) begin
            rd(ofs[i], d);
            `CHK(d, `RST_REG8)
            s8 = 8'(rnd());
            wr(ofs[i], s8);
            rd(ofs[i], d);
            `CHK(d, s8)
            wr(ofs[i], 8'h00);
        end
        wr(12'h0fc9, 8'h5a);
        rd(12'h0fc9, d);
        `CHK(d, 8'h00)
        en(16'hffff, 16'hffff);
        for (int k = 0; k < 5; k++) begin
            pulse(k);
            rq(p);
            `CHK(p, k < 4 ? 16'h0001 << k : 16'h0000)
            clr();
        end
        `CHK(taken, 0)
        s8 = 8'(rnd());
        for (int k = 0; k < 24; k++) begin
            w = k % 12;
            wr(`OFS_EDGE_POLARITY_SELECT, k < 12 ? s8 : ~s8);
            for (int v = 1; v >= 0; v--) begin
                pin(w, v[0]);
                rq(p);
                `CHK(p[w + 4], w > 7 || ((k < 12) ^ s8[w % 8]) == (v == 1))
                clr();
            end
        end
        wr(`OFS_SHARED_SOURCE_SELECT, 8'h40);
        pin(6, 1'b1);
        pin(6, 1'b0);
        rq(p);
        `CHK(p, 16'h0000)
        pulse(4);
        rq(p);
        `CHK(p, 16'h0400)
        clr();
        wr(`OFS_SHARED_SOURCE_SELECT, 8'h00);
        wr(`OFS_IRQ_MASK, 8'h01);
        exp_n = 0;
        for (int r = 0; r < 6; r++) begin
            en(r == 0 ? 16'hffff : 16'(rnd()), r == 0 ? 16'h0000 : 16'(rnd()));
            p = r == 0 ? 16'hffff : 16'(rnd());
            wr(`OFS_REQUEST_GROUP0, p[7:0]);
            wr(`OFS_REQUEST_GROUP1, p[15:8]);
            w = win(p);
            rd(`OFS_ACTIVE_VECTOR, d);
            `CHK(d, w < 0 ? 8'h00 : {2'b10, ehi[w], elo[w], 4'(w)})
            @(posedge clk_sys_in);
            dly <= 4'(r % 4);
            vectored_mode_in <= 1'b1;
            q = p;
            w = win(q);
            while (w >= 0) begin
                n = taken;
                for (int c = 0; c < 40 && taken == n; c++) @(posedge clk_sys_in);
                `CHK(taken_vec, 4'(w))
                `CHK(handler, hexp(w))
                exp_n++;
                q[w] = 1'b0;
                w = win(q);
            end
            repeat (20) @(posedge clk_sys_in);
            `CHK(taken, exp_n)
            @(posedge clk_sys_in);
            vectored_mode_in <= 1'b0;
            clr();
        end
        `CHK(irq_out, 1'b1)
        rd(`OFS_IRQ_STATUS, d);
        `CHK(d[0], 1'b1)
        repeat (3) @(posedge clk_sys_in);
        `CHK(irq_out, 1'b0)
        rd(`OFS_IRQ_STATUS, d);
        `CHK(d, 8'h00)
        results();
    end
endmodule
